/* hdl/asc_pkg.sv */
// How it works
// R1 - loop select feeds receiver from transmitter
// R2 - software enables both directions for loop
// R3 - source bit picks internal or transmit pin
// R4 - halt in wait freezes the block
// R5 - start, eight or nine data, stop
// R6 - wake on idle line or address mark
// R7 - idle ones counted after start or stop
// R8 - parity replaces top data bit both ways
// R9 - even or odd parity bit value
// R10 - holding empty interrupt gated by enable
// R11 - transmit done interrupt gated by enable
// R12 - receive full or overrun share enable
// R13 - idle line interrupt gated by enable
// R14 - transmit enable takes the transmit pin
// R15 - rising transmit enable queues idle preamble
// R16 - receive enable starts and stops receiver
// R17 - standby suppresses receive interrupts, self clears
// R18 - send break edge sends one break
// R19 - software clears break bit before finish
// R20 - held break bit repeats break characters
// R21 - baud generator sleeps until first enable
// R22 - wait halt pauses, resumes, keeps enables
// R23 - break is 10/11, long 13/14
package asc_pkg;
    // register word indices; byte address is four times the index
    localparam logic [2:0] IDX_BAUD = 3'h0;
    localparam logic [2:0] IDX_FMT = 3'h2;
    localparam logic [2:0] IDX_CTL = 3'h3;
    localparam logic [2:0] IDX_STAT = 3'h4;
    localparam logic [2:0] IDX_EXT = 3'h5;
    localparam logic [2:0] IDX_DATA = 3'h7;
    // control_frame_format fields
    localparam int FMT_LOOP = 7;
    localparam int FMT_HALT = 6;
    localparam int FMT_RECEIVER_SOURCE = 5;
    localparam int FMT_NINE = 4;
    localparam int FMT_WAKE = 3;
    localparam int FMT_ILT = 2;
    localparam int FMT_PAR = 1;
    localparam int FMT_ODD = 0;
    // control_enables_and_irq fields
    localparam int CTL_TIE = 7;
    localparam int CTL_TX_DONE_IRQ_EN = 6;
    localparam int CTL_RIE = 5;
    localparam int CTL_IDLE_IRQ_EN = 4;
    localparam int CTL_TE = 3;
    localparam int CTL_RE = 2;
    localparam int CTL_RWU = 1;
    localparam int CTL_SBK = 0;
    // extension register field
    localparam int EXT_LONG = 2;
    // reset values
    localparam logic [7:0] FMT_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [12:0] BAUD_DEFAULT = 13'h0004;
    // timing counts in oversample ticks and bits
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [3:0] CHAR_BITS_8 = 4'ha;
    localparam logic [3:0] CHAR_BITS_9 = 4'hb;
    localparam logic [3:0] DATA_BITS_8 = 4'h8;
    localparam logic [3:0] DATA_BITS_9 = 4'h9;
    localparam logic [3:0] BRK_EXTRA = 4'h3;
    // state machines
    typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} asc_tx_state_t;
    typedef enum logic {RX_HUNT = 1'b0, RX_FRAME = 1'b1} asc_rx_state_t;
endpackage

/* hdl/asc_serial_ctrl.sv */
`timescale 1ns/1ps
module asc_serial_ctrl
    import asc_pkg::*;
#(
    parameter logic [12:0] BAUD_RESET = BAUD_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_cpu_wait,
    input wire logic i_rx_pin,
    input wire logic i_tx_pin,
    output logic o_tx_pin,
    output logic o_tx_pin_oe_n,
    output logic o_irq_req
);

    // a zero divisor would leave the block silent from reset
    if (BAUD_RESET == 13'h0000) begin : g_bad_baud
        $error("BAUD_RESET must be nonzero");
    end

    // every flip-flop of the block lives in this one record
    typedef struct packed {
        logic [12:0] baud;       // bit rate divisor
        logic [7:0] fmt;         // control_frame_format
        logic [7:0] ctl;         // control_enables_and_irq
        logic long_brk;          // long_break
        logic started;           // baud generator released
        logic [12:0] div;        // oversample divider
        logic tick;              // one-cycle oversample enable
        logic [2:0] rx_sync;     // receive pin synchroniser
        logic [2:0] txp_sync;    // transmit pin read-back synchroniser
        logic rx_lvl;            // filtered receive pin
        logic txp_lvl;           // filtered transmit pin
        asc_tx_state_t tx_st;
        logic [8:0] tx_hold;     // transmit holding word
        logic hold_empty;        // tx_holding_empty
        logic tx_done;           // tx_done
        logic [13:0] tx_sh;      // transmit shifter, lsb goes first
        logic [3:0] tx_left;     // bits still to send
        logic [3:0] tx_sub;      // ticks within a bit
        logic tx_pin;            // transmitter output
        logic pre_pend;          // idle preamble queued
        logic brk_pend;          // one break queued
        logic te_prev;
        logic sbk_prev;
        asc_rx_state_t rx_st;
        logic [3:0] rx_sub;      // ticks within a bit
        logic [3:0] rx_bits;     // bit index within the frame
        logic [8:0] rx_sh;       // receive shifter
        logic [8:0] rx_data;     // received word
        logic rx_full;           // rx_holding_full
        logic ovr;               // overrun_flag
        logic fe;                // framing error
        logic pf;                // parity error
        logic idle;              // idle line flag
        logic idle_arm;          // a character came since last idle
        logic [3:0] ones;        // consecutive ones toward idle
        logic rdy;               // bus answer
        logic slverr;
        logic [31:0] rdata;
    } asc_state_t;

    asc_state_t st_q;
    asc_state_t st_d;

    logic halted;           // processor waiting with halt enabled
    logic nine;
    logic parity_on;
    logic odd;
    logic [3:0] frame_bits;
    logic [3:0] brk_bits;
    logic [3:0] data_bits;
    logic [2:0] idx;
    logic hit;
    logic acc;              // bus transfer completes at this edge
    logic [31:0] rd_mux;
    logic rx_src;           // receiver input after routing
    logic par_lo;
    logic [8:0] tx_char;
    logic [13:0] data_frame;
    logic [8:0] rx_char;
    logic rx_msb;
    logic rx_par_bad;
    logic ld_data;
    logic ld_brk;
    logic ld_pre;
    logic [3:0] ones_inc;

    // frame shape from the format and extension registers
    assign halted = st_q.fmt[FMT_HALT] & i_cpu_wait; // [R4]
    assign nine = st_q.fmt[FMT_NINE];
    assign parity_on = st_q.fmt[FMT_PAR];
    assign odd = st_q.fmt[FMT_ODD];
    assign frame_bits = nine ? CHAR_BITS_9 : CHAR_BITS_8; // [R5]
    assign data_bits = nine ? DATA_BITS_9 : DATA_BITS_8; // [R5]
    assign brk_bits = st_q.long_brk ? frame_bits + BRK_EXTRA : frame_bits; // [R23]
    assign ones_inc = st_q.ones + 4'h1;

    // bus decode: word aligned, six registers in eight words
    assign idx = i_paddr[4:2];
    assign hit = (i_paddr[1:0] == 2'h0) && (i_paddr[7:5] == 3'h0)
        && (idx == IDX_BAUD || idx == IDX_FMT || idx == IDX_CTL
        || idx == IDX_STAT || idx == IDX_EXT || idx == IDX_DATA);
    assign acc = i_psel & i_penable & st_q.rdy;

    // receiver routing: normal pin, internal loop or single wire
    assign rx_src = !st_q.fmt[FMT_LOOP] ? st_q.rx_lvl // [R3]
        : (st_q.fmt[FMT_RECEIVER_SOURCE] ? st_q.txp_lvl : st_q.tx_pin); // [R1]

    // parity lands in the top data bit; even parity bit is the xor
    assign par_lo = nine ? ^st_q.tx_hold[7:0] : ^st_q.tx_hold[6:0]; // [R9]
    always_comb begin
        if (!parity_on) begin
            tx_char = nine ? st_q.tx_hold : {1'b0, st_q.tx_hold[7:0]};
        end else if (nine) begin
            tx_char = {par_lo ^ odd, st_q.tx_hold[7:0]}; // [R8]
        end else begin
            tx_char = {1'b0, par_lo ^ odd, st_q.tx_hold[6:0]}; // [R8]
        end
    end
    // stop ones fill above the data, start zero below
    assign data_frame = nine ? {4'hf, tx_char, 1'b0} : {5'h1f, tx_char[7:0], 1'b0}; // [R5]

    // received word, msb and parity check
    assign rx_char = nine ? st_q.rx_sh : {1'b0, st_q.rx_sh[8:1]};
    assign rx_msb = nine ? rx_char[8] : rx_char[7];
    assign rx_par_bad = (nine ? ^rx_char : ^rx_char[7:0]) ^ odd; // [R9]

    // read data selection
    always_comb begin
        case (idx)
            IDX_BAUD: rd_mux = {19'h0, st_q.baud};
            IDX_FMT: rd_mux = {24'h0, st_q.fmt};
            IDX_CTL: rd_mux = {24'h0, st_q.ctl};
            IDX_STAT: rd_mux = {24'h0, st_q.hold_empty, st_q.tx_done, st_q.rx_full,
                st_q.idle, st_q.ovr, 1'b0, st_q.fe, st_q.pf};
            IDX_EXT: rd_mux = 32'(st_q.long_brk) << EXT_LONG;
            IDX_DATA: rd_mux = {23'h0, st_q.rx_data};
            default: rd_mux = 32'h0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        st_d = st_q;
        ld_data = 1'b0;
        ld_brk = 1'b0;
        ld_pre = 1'b0;
        // pin synchronisers; a level counts once stages two and three agree
        st_d.rx_sync = {st_q.rx_sync[1:0], i_rx_pin};
        st_d.txp_sync = {st_q.txp_sync[1:0], i_tx_pin};
        if (st_q.rx_sync[1] == st_q.rx_sync[2]) begin
            st_d.rx_lvl = st_q.rx_sync[2];
        end
        if (st_q.txp_sync[1] == st_q.txp_sync[2]) begin
            st_d.txp_lvl = st_q.txp_sync[2];
        end

        // oversample divider; stops in wait when halt is enabled so transfers pause in place
        st_d.tick = 1'b0;
        if (st_q.started && st_q.baud != 13'h0000 && !halted) begin // [R21] [R22]
            if (st_q.div >= st_q.baud - 13'h0001) begin
                st_d.div = 13'h0000;
                st_d.tick = 1'b1;
            end else begin
                st_d.div = st_q.div + 13'h0001;
            end
        end

        // edge detectors for queued preamble and break
        st_d.te_prev = st_q.ctl[CTL_TE];
        st_d.sbk_prev = st_q.ctl[CTL_SBK];
        if (st_q.ctl[CTL_TE] && !st_q.te_prev) begin
            st_d.pre_pend = 1'b1; // [R15]
        end
        if (st_q.ctl[CTL_SBK] && !st_q.sbk_prev) begin
            st_d.brk_pend = 1'b1; // [R18]
        end

        // transmitter: break beats preamble beats data
        case (st_q.tx_st)
            TX_IDLE: begin
                if (st_q.ctl[CTL_TE] && !halted) begin // [R14] [R22]
                    if (st_q.ctl[CTL_SBK] || st_q.brk_pend) begin
                        ld_brk = 1'b1; // [R20]
                        st_d.tx_sh = 14'h0000;
                        st_d.tx_left = brk_bits; // [R23]
                        st_d.brk_pend = 1'b0;
                    end else if (st_q.pre_pend) begin
                        ld_pre = 1'b1; // [R15]
                        st_d.tx_sh = 14'h3fff;
                        st_d.tx_left = frame_bits;
                        st_d.pre_pend = 1'b0;
                    end else if (!st_q.hold_empty) begin
                        ld_data = 1'b1;
                        st_d.tx_sh = data_frame; // [R5]
                        st_d.tx_left = frame_bits;
                        st_d.hold_empty = 1'b1;
                    end
                    if (ld_brk || ld_pre || ld_data) begin
                        st_d.tx_st = TX_SHIFT;
                        st_d.tx_sub = 4'h0;
                        st_d.tx_pin = st_d.tx_sh[0];
                    end
                end
            end
            TX_SHIFT: begin
                if (st_q.tick) begin
                    st_d.tx_sub = st_q.tx_sub + 4'h1;
                    if (st_q.tx_sub == SUB_LAST) begin
                        if (st_q.tx_left == 4'h1) begin
                            // line returns to idle between characters
                            st_d.tx_st = TX_IDLE;
                            st_d.tx_pin = 1'b1;
                        end else begin
                            st_d.tx_sh = {1'b1, st_q.tx_sh[13:1]};
                            st_d.tx_pin = st_q.tx_sh[1];
                            st_d.tx_left = st_q.tx_left - 4'h1;
                        end
                    end
                end
            end
            default: st_d.tx_st = TX_IDLE;
        endcase

        // bus slave: one wait cycle so that read data comes from a flop
        st_d.rdy = i_psel & i_penable & !st_q.rdy;
        st_d.slverr = i_psel & i_penable & !st_q.rdy & !hit;
        if (i_psel && i_penable && !st_q.rdy) begin
            st_d.rdata = hit ? rd_mux : 32'h0; // refused reads return zero
        end
        if (acc && hit && i_pwrite) begin
            case (idx)
                IDX_BAUD: st_d.baud = i_pwdata[12:0];
                IDX_FMT: st_d.fmt = i_pwdata[7:0];
                IDX_CTL: begin
                    // enables are untouched by the wait halt bit
                    st_d.ctl = i_pwdata[7:0]; // [R22]
                    if (i_pwdata[CTL_TE] || i_pwdata[CTL_RE]) begin
                        st_d.started = 1'b1; // [R21]
                    end
                end
                IDX_EXT: st_d.long_brk = i_pwdata[EXT_LONG];
                IDX_DATA: begin
                    st_d.tx_hold = i_pwdata[8:0];
                    st_d.hold_empty = 1'b0;
                end
                default: st_d.fmt = st_q.fmt;
            endcase
        end
        // reading the data word releases the receive flags
        if (acc && hit && !i_pwrite && idx == IDX_DATA) begin
            st_d.rx_full = 1'b0;
            st_d.ovr = 1'b0;
            st_d.fe = 1'b0;
            st_d.pf = 1'b0;
            st_d.idle = 1'b0;
        end

        // receiver; its flag sets come last so a set beats a clear
        if (!st_q.ctl[CTL_RE]) begin
            st_d.rx_st = RX_HUNT; // [R16]
            st_d.rx_sub = 4'h0;
        end else if (st_q.tick) begin
            st_d.rx_sub = st_q.rx_sub + 4'h1;
            case (st_q.rx_st)
                RX_HUNT: begin
                    if (!rx_src) begin
                        // falling edge: mid start bit comes eight ticks on
                        st_d.rx_st = RX_FRAME;
                        st_d.rx_sub = 4'h0;
                        st_d.rx_bits = 4'h0;
                    end else if (st_q.rx_sub == SUB_LAST && st_q.ones != frame_bits) begin
                        st_d.ones = ones_inc;
                        if (ones_inc == frame_bits && st_q.idle_arm) begin
                            st_d.idle = 1'b1;
                            st_d.idle_arm = 1'b0;
                            if (st_q.ctl[CTL_RWU] && !st_q.fmt[FMT_WAKE]) begin
                                st_d.ctl[CTL_RWU] = 1'b0; // [R6] [R17]
                            end
                        end
                    end
                end
                RX_FRAME: begin
                    if (st_q.rx_sub == SUB_MID) begin
                        st_d.rx_bits = st_q.rx_bits + 4'h1;
                        if (st_q.rx_bits == 4'h0) begin
                            st_d.ones = 4'h0;
                            if (rx_src) begin
                                st_d.rx_st = RX_HUNT; // false start, glitch
                            end
                        end else if (st_q.rx_bits <= data_bits) begin
                            st_d.rx_sh = {rx_src, st_q.rx_sh[8:1]};
                            if (!st_q.fmt[FMT_ILT]) begin
                                st_d.ones = rx_src ? ones_inc : 4'h0; // [R7]
                            end
                        end else begin
                            // stop bit: the character is complete
                            st_d.rx_st = RX_HUNT;
                            st_d.rx_sub = 4'h0;
                            st_d.idle_arm = 1'b1;
                            if (st_q.fmt[FMT_ILT]) begin
                                st_d.ones = 4'h0; // [R7]
                            end else begin
                                st_d.ones = rx_src ? ones_inc : 4'h0; // [R7]
                            end
                            if (st_q.ctl[CTL_RWU] && st_q.fmt[FMT_WAKE] && rx_msb) begin
                                st_d.ctl[CTL_RWU] = 1'b0; // [R6] [R17]
                            end
                            // in standby only an address mark gets through
                            if (!st_q.ctl[CTL_RWU] || (st_q.fmt[FMT_WAKE] && rx_msb)) begin
                                if (st_q.rx_full) begin
                                    st_d.ovr = 1'b1;
                                end else begin
                                    st_d.rx_data = rx_char;
                                    st_d.rx_full = 1'b1;
                                    st_d.fe = !rx_src;
                                    st_d.pf = parity_on & rx_par_bad; // [R8]
                                end
                            end
                        end
                    end
                end
                default: st_d.rx_st = RX_HUNT;
            endcase
        end

        // done means idle line with nothing waiting to go
        st_d.tx_done = (st_d.tx_st == TX_IDLE) && st_d.hold_empty
            && !st_d.pre_pend && !st_d.brk_pend;
    end

    // state register
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= '0;
            st_q.baud <= BAUD_RESET;
            st_q.fmt <= FMT_RESET;
            st_q.ctl <= CTL_RESET;
            st_q.rx_sync <= 3'h7;
            st_q.txp_sync <= 3'h7;
            st_q.rx_lvl <= 1'b1;
            st_q.txp_lvl <= 1'b1;
            st_q.hold_empty <= 1'b1;
            st_q.tx_done <= 1'b1;
            st_q.tx_sh <= 14'h3fff;
            st_q.tx_pin <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs
    assign o_prdata = st_q.rdata;
    assign o_pready = st_q.rdy;
    assign o_pslverr = st_q.slverr;
    assign o_tx_pin = st_q.tx_pin;
    // pin is released when the transmitter is off and idle
    assign o_tx_pin_oe_n = !(st_q.ctl[CTL_TE] || st_q.tx_st == TX_SHIFT); // [R14]
    // standby hides the receiver sources only
    assign o_irq_req = (st_q.ctl[CTL_TIE] & st_q.hold_empty) // [R10]
        | (st_q.ctl[CTL_TX_DONE_IRQ_EN] & st_q.tx_done) // [R11]
        | (!st_q.ctl[CTL_RWU] & st_q.ctl[CTL_RIE] & (st_q.rx_full | st_q.ovr)) // [R12] [R17]
        | (!st_q.ctl[CTL_RWU] & st_q.ctl[CTL_IDLE_IRQ_EN] & st_q.idle); // [R13] [R17]

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_loop_path: assert property ( // [R1]
        (st_q.fmt[FMT_LOOP] && !st_q.fmt[FMT_RECEIVER_SOURCE]) |-> rx_src == st_q.tx_pin)
        else $error("loop receiver not fed from transmitter");
    a_rx_routing: assert property ( // [R3]
        (st_q.fmt[FMT_LOOP] ? (st_q.fmt[FMT_RECEIVER_SOURCE] ? rx_src == st_q.txp_lvl : 1'b1)
        : rx_src == st_q.rx_lvl))
        else $error("receiver input routed wrongly");
    // a tick already in flight on wait entry may still land, so judge from the second cycle
    a_wait_freeze: assert property ( // [R4]
        halted ##1 halted |-> !st_q.tick ##1 $stable(st_q.tx_sub))
        else $error("block advanced while halted in wait");
    a_char_length: assert property ( // [R5]
        ld_data |=> st_q.tx_st == TX_SHIFT && st_q.tx_left == $past(frame_bits)
        && !st_q.tx_sh[0] && !o_tx_pin)
        else $error("data character length or start bit wrong");
    a_parity_bit: assert property ( // [R9]
        (ld_data && parity_on && nine) |=> (^st_q.tx_sh[9:1]) == $past(odd))
        else $error("nine bit parity wrong");
    a_break_len: assert property ( // [R23]
        ld_brk |=> st_q.tx_sh == 14'h0000 && st_q.tx_left == $past(brk_bits))
        else $error("break length wrong");
    a_break_repeat: assert property ( // [R20]
        (st_q.tx_st == TX_IDLE && st_q.ctl[CTL_TE] && st_q.ctl[CTL_SBK] && !halted)
        |-> ld_brk)
        else $error("held break bit did not start another break");
    a_tx_release: assert property ( // [R14]
        (!st_q.ctl[CTL_TE] && st_q.tx_st == TX_IDLE) |-> o_tx_pin_oe_n && o_tx_pin)
        else $error("transmit pin held while transmitter off");
    a_rx_stop: assert property ( // [R16]
        !st_q.ctl[CTL_RE] |=> st_q.rx_st == RX_HUNT ##1 st_q.ctl[CTL_RE] || !st_q.rx_full
        || $stable(st_q.rx_data))
        else $error("receiver ran while disabled");
    a_baud_asleep: assert property ( // [R21]
        !st_q.started |-> !st_q.tick && st_q.div == 13'h0000)
        else $error("baud generator ran before first enable");
    a_standby_quiet: assert property ( // [R17]
        (st_q.ctl[CTL_RWU] && !st_q.ctl[CTL_TIE] && !st_q.ctl[CTL_TX_DONE_IRQ_EN]) |-> !o_irq_req)
        else $error("receiver interrupt raised in standby");
    a_irq_cause: assert property ( // [R12]
        (o_irq_req && !st_q.ctl[CTL_TIE] && !st_q.ctl[CTL_TX_DONE_IRQ_EN] && !st_q.ctl[CTL_IDLE_IRQ_EN])
        |-> st_q.ctl[CTL_RIE] && (st_q.rx_full || st_q.ovr))
        else $error("interrupt without enabled cause");
    a_preamble_queue: assert property ( // [R15]
        (st_q.ctl[CTL_TE] && !st_q.te_prev) |=> st_q.pre_pend || st_q.tx_st == TX_SHIFT)
        else $error("enable edge lost the idle preamble");

endmodule // asc_serial_ctrl

/* tb/asc_remote_peer.sv */
`timescale 1ns/1ps
// far-side serial device; divisor 1 gives 16 clocks per bit
module asc_remote_peer (
    input wire logic i_clk,
    input wire logic i_line,
    output logic o_line
);
    initial o_line = 1'b1; // mark level between frames
    // start, n data bits lsb first, stop
    task automatic send(input logic [8:0] w, input int n);
        for (int b = 0; b < n + 2; b++) begin
            o_line <= (b == 0) ? 1'b0 : (b > n) ? 1'b1 : w[b-1];
            repeat (16) @(posedge i_clk);
        end
    endtask
    // sample mid-bit after the start edge; bit n is the stop bit
    task automatic grab(input int n, output logic [9:0] w);
        int t;
        w = '0;
        t = 0;
        while (i_line !== 1'b0 && t < 5000) begin
            @(posedge i_clk);
            t++;
        end
        repeat (8) @(posedge i_clk);
        for (int b = 0; b <= n; b++) begin
            repeat (16) @(posedge i_clk);
            w[b] = i_line;
        end
    endtask
    // length of a low run in bit times, rounded since we may join late
    task automatic zeros(output int z);
        int c;
        c = 0;
        while (i_line !== 1'b0 && c < 5000) begin
            @(posedge i_clk);
            c++;
        end
        c = 0;
        while (i_line === 1'b0 && c < 400) begin
            @(posedge i_clk);
            c++;
        end
        z = (c + 8) / 16;
    endtask
endmodule // asc_remote_peer

/* tb/test_async_serial_control_settings.sv */
`timescale 1ns/1ps
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin fails++; \
    $display("ERROR %0t: got %h exp %h", $time, g, x); end end
module test_async_serial_control_settings;
    import asc_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, cwait = 0, e;
    logic [7:0] pa = 0, f;
    logic [31:0] pwd = 0, q, rdat;
    logic rdy, err, txo, oe_n, irq, rxl;
    wire txw = oe_n ? 1'b1 : txo; // pull-up while the pin is released
    int fails = 0, n_checks = 0, z;
    logic [9:0] got;
    logic [8:0] w;
    asc_serial_ctrl #(.BAUD_RESET(13'h0001)) i_asc_serial_ctrl (.i_clk(clk), .i_reset_n(rst_n),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(rdat), .o_pready(rdy), .o_pslverr(err), .i_cpu_wait(cwait), .i_rx_pin(rxl),
        .i_tx_pin(txw), .o_tx_pin(txo), .o_tx_pin_oe_n(oe_n), .o_irq_req(irq));
    asc_remote_peer i_asc_remote_peer (.i_clk(clk), .i_line(txw), .o_line(rxl));
    initial forever #10 clk = ~clk;
    // one transfer, held until pready is sampled high, then an idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1;
        pwr <= wr;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
            t++;
        end while (rdy !== 1'b1 && t < 20);
        if (rdy !== 1'b1) fails++; // no answer counts as a mismatch
        q = rdat;
        e = err;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    // expected data and stop bits as sampled by the peer
    function automatic logic [9:0] fexp(logic [8:0] d, logic nine, logic par, logic odd);
        logic [8:0] m;
        m = nine ? d : {1'b0, d[7:0]};
        if (par) m[nine ? 8 : 7] = ^(nine ? d[7:0] : {1'b0, d[6:0]}) ^ odd;
        return nine ? {1'b1, m} : {2'b01, m[7:0]};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog, well above the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clk);
        fails++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h7210));
        repeat (20) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        apb(0, 8'h08, 0);
        `CHK(q, 32'h0)
        apb(0, 8'h10, 0);
        `CHK(q, 32'hc0)
        apb(0, 8'h04, 0);
        `CHK(e, 1'b1)
        apb(1, 8'h0c, 32'h0c); // both directions on, as loop use needs
        `CHK(irq, 1'b0)
        $display("test registers done");
        // random formats over nine bit, parity and odd; data words fully random
        for (int k = 0; k < 6; k++) begin
            f = 8'h13 & $urandom;
            w = $urandom;
            apb(1, 8'h08, {24'h0, f});
            apb(1, 8'h1c, {23'h0, w});
            i_asc_remote_peer.grab(f[4] ? 9 : 8, got);
            `CHK(got, fexp(w, f[4], f[1], f[0]))
            repeat (32) @(posedge clk);
        end
        apb(1, 8'h0c, 32'h4c);
        `CHK(irq, 1'b1)
        apb(1, 8'h0c, 32'h8c);
        `CHK(irq, 1'b1)
        $display("test transmit done");
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'h08, {27'h0, k[0], 4'h0});
            apb(1, 8'h14, {29'h0, k[1], 2'h0});
            apb(1, 8'h0c, 32'h0d);
            apb(1, 8'h0c, 32'h0c); // cleared before the break ends
            i_asc_remote_peer.zeros(z);
            `CHK(z, 10 + k[0] + 3 * k[1])
            repeat (48) @(posedge clk);
        end
        $display("test break done");
        apb(1, 8'h08, 32'h80);
        w = $urandom;
        apb(1, 8'h1c, {23'h0, w});
        repeat (240) @(posedge clk);
        apb(0, 8'h1c, 0);
        `CHK(q[7:0], w[7:0])
        apb(1, 8'h08, 32'h00);
        apb(1, 8'h0c, 32'h2c);
        w = $urandom;
        i_asc_remote_peer.send(w, 8);
        `CHK(irq, 1'b1)
        apb(0, 8'h1c, 0);
        `CHK(q[7:0], w[7:0])
        `CHK(irq, 1'b0)
        $display("test receive done");
        // address mark wake: a plain character is dropped while in standby
        apb(1, 8'h08, 32'h08);
        apb(1, 8'h0c, 32'h2e);
        i_asc_remote_peer.send(9'h055, 8);
        `CHK(irq, 1'b0)
        i_asc_remote_peer.send(9'h0c3, 8);
        `CHK(irq, 1'b1)
        apb(0, 8'h0c, 0);
        `CHK(q[7:0], 8'h2c)
        apb(0, 8'h1c, 0);
        `CHK(q[7:0], 8'hc3)
        $display("test standby done");
        // halt in wait: a character pauses mid-frame and finishes afterwards
        apb(1, 8'h08, 32'h40);
        apb(1, 8'h1c, {23'h0, w});
        repeat (40) @(posedge clk);
        cwait <= 1;
        repeat (300) @(posedge clk);
        apb(0, 8'h10, 0);
        `CHK(q[7:6], 2'b10)
        apb(0, 8'h0c, 0);
        `CHK(q[7:0], 8'h2c)
        cwait <= 0;
        repeat (200) @(posedge clk);
        apb(0, 8'h10, 0);
        `CHK(q[7:6], 2'b11)
        $display("test wait done");
        tally_and_finish;
    end
endmodule // test_async_serial_control_settings
